// >>> src/uart_chan.sv
// One serial channel: queues, level interrupts, mode pointer, flow control, APB slave
//
// Our own choice: the APB interface to the registers.
`include "uart_chan_defs.svh"

//------------------------------------------------------------
// Character queue
//------------------------------------------------------------
module uart_queue #(
    parameter int W = 11
) (
    input  wire logic         clk,    // Clock
    input  wire logic         rst_n,  // Async reset
    input  wire logic         flush,  // Empty the queue
    input  wire logic [4:0]   depth,  // Usable slots
    input  wire logic         push,   // Write strobe
    input  wire logic [W-1:0] wdata,  // Write data
    input  wire logic         pop,    // Read strobe
    output logic      [W-1:0] rdata,  // Top entry
    output logic      [4:0]   count   // Entries held
);
    logic [W-1:0] mem [0:15];
    logic [3:0]   rd_q;
    logic [3:0]   wr_q;
    logic [4:0]   cnt_q;
    wire          do_push = push && (cnt_q < depth);
    wire          do_pop  = pop && (cnt_q != 5'h00);

    assign rdata = mem[rd_q];
    assign count = cnt_q;

    always_ff @(posedge clk)
    begin
        if (do_push)
            mem[wr_q] <= wdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_q  <= 4'h0;
            wr_q  <= 4'h0;
            cnt_q <= 5'h00;
        end
        else if (flush)
        begin
            rd_q  <= 4'h0;
            wr_q  <= 4'h0;
            cnt_q <= 5'h00;
        end
        else
        begin
            if (do_push)
                wr_q <= wr_q + 4'h1;
            if (do_pop)
                rd_q <= rd_q + 4'h1;
            cnt_q <= cnt_q + {4'h0, do_push} - {4'h0, do_pop};
        end
    end
endmodule

//------------------------------------------------------------
// Channel top
//------------------------------------------------------------
module uart_chan (
    input  wire logic        CLK,      // 10 MHz clock
    input  wire logic        RESET_N,  // Async reset, active low
    input  wire logic        PSEL,     // APB select
    input  wire logic        PENABLE,  // APB access phase
    input  wire logic        PWRITE,   // APB direction
    input  wire logic [7:0]  PADDR,    // APB byte address
    input  wire logic [31:0] PWDATA,   // APB write data
    output logic      [31:0] PRDATA,   // APB read data
    output logic             PREADY,   // APB ready
    output logic             PSLVERR,  // APB error, unmapped
    input  wire logic        RXD,      // Serial in
    output logic             TXD,      // Serial out
    input  wire logic        CLEAR_TO_SEND_N, // Remote permits send
    output logic             CHANNEL_A_REQUEST_TO_SEND_N, // Flow output
    output logic             OUTPUT_PIN_ONE, // Port latch bit 1
    output logic             RX_LEVEL_REQ,   // Receive fill request
    output logic             TX_LEVEL_REQ,   // Transmit fill request
    output logic             IRQ        // Masked interrupt, level
);
    import uart_chan_pkg::*;

    //------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------
    logic [7:0]  mode_one_q;
    logic [7:0]  mode_two_q;
    logic [7:0]  mode_zero_q;
    logic [1:0]  out_port_q;
    irq_bits_s   irq_stat_q;
    irq_bits_s   irq_mask_q;
    logic        ptr_q;
    wire         acc     = PSEL && PENABLE;
    wire         wr      = acc && PWRITE;
    wire         rd      = acc && !PWRITE;
    wire         hit_m1  = PADDR == `OFS_MODE_ONE;
    wire         hit_m0  = PADDR == `OFS_MODE_ZERO;
    wire         hit_cmd = PADDR == `OFS_COMMAND;
    wire         hit_st  = PADDR == `OFS_STATUS;
    wire         hit_dat = PADDR == `OFS_DATA;
    wire         hit_op  = PADDR == `OFS_OUT_PORT;
    wire         hit_is  = PADDR == `OFS_IRQ_STATUS;
    wire         hit_im  = PADDR == `OFS_IRQ_MASK;
    wire         mapped  = hit_m1 | hit_m0 | hit_cmd | hit_st
                         | hit_dat | hit_op | hit_is | hit_im;
    wire [3:0]   cmd     = PWDATA[7:4];
    wire         cmd_wr  = wr && hit_cmd;
    wire         rx_rst  = cmd_wr && cmd == `CMD_RX_RESET;
    wire         err_rst = cmd_wr && cmd == `CMD_ERR_RESET;
    wire         rx_pop  = rd && hit_dat;
    wire         tx_push = wr && hit_dat;

    assign PREADY  = 1'b1;
    assign PSLVERR = acc && !mapped;

    //------------------------------------------------------------
    // Mode registers and pointer
    //------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ptr_q       <= 1'b0;
            mode_one_q  <= `RESET_MODE;
            mode_two_q  <= `RESET_MODE;
            mode_zero_q <= `RESET_MODE;
            out_port_q  <= 2'b00;
            irq_mask_q  <= '0;
        end
        else
        begin
            if (cmd_wr && cmd == `CMD_SET_POINTER)
                ptr_q <= 1'b0;
            else if (acc && hit_m1 && !ptr_q)
                ptr_q <= 1'b1;
            if (wr && hit_m1 && !ptr_q)
                mode_one_q <= PWDATA[7:0];
            if (wr && hit_m1 && ptr_q)
                mode_two_q <= PWDATA[7:0];
            if (wr && hit_m0)
                mode_zero_q <= PWDATA[7:0];
            if (wr && hit_op)
                out_port_q <= PWDATA[1:0];
            if (wr && hit_im)
                irq_mask_q <= PWDATA[2:0];
        end
    end

    //------------------------------------------------------------
    // Queues
    //------------------------------------------------------------
    rx_char_s    rx_top;
    rx_char_s    rx_in_q;
    logic [4:0]  rx_cnt;
    logic [4:0]  tx_cnt;
    logic [7:0]  tx_top;
    logic        rx_push;
    logic        tx_pop;
    logic        depth_q;
    wire  [4:0]  depth = depth_q ? `QUEUE_MAX : `QUEUE_SMALL;
    wire         rx_full = rx_cnt == depth;

    uart_queue #(.W(11)) rx_queue (
        .clk   (CLK),
        .rst_n (RESET_N),
        .flush (rx_rst),
        .depth (depth),
        .push  (rx_push),
        .wdata (rx_in_q),
        .pop   (rx_pop),
        .rdata (rx_top),
        .count (rx_cnt)
    );

    uart_queue #(.W(8)) tx_queue (
        .clk   (CLK),
        .rst_n (RESET_N),
        .flush (1'b0),
        .depth (depth),
        .push  (tx_push),
        .wdata (PWDATA[7:0]),
        .pop   (tx_pop),
        .rdata (tx_top),
        .count (tx_cnt)
    );

    //------------------------------------------------------------
    // Fill levels
    //------------------------------------------------------------
    // Levels are taken over at a queue event or while both queues are empty, so a change made with
    // characters in flight cannot glitch the request.
    logic [1:0] rx_code_q;
    logic [1:0] tx_code_q;
    wire        q_event = rx_pop | tx_push | rx_push | tx_pop;
    wire        both_empty = rx_cnt == 5'h00 && tx_cnt == 5'h00;
    wire [1:0]  rx_code_new = {mode_zero_q[`MODE_ZERO_RXHIGH],
                               mode_one_q[`MODE_ONE_RXLOW]};
    wire [4:0]  tx_free = depth - tx_cnt;
    logic [4:0] rx_thr;
    logic [4:0] tx_thr;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rx_code_q <= 2'b00;
            tx_code_q <= 2'b00;
            depth_q   <= 1'b0;
        end
        else if (q_event || both_empty)
        begin
            rx_code_q <= rx_code_new;
            tx_code_q <= mode_zero_q[5:4];
            depth_q   <= mode_zero_q[`MODE_ZERO_DEPTH];
        end
    end

    always_comb
    begin
        case (rx_code_q)
            2'b00:   rx_thr = 5'h01;
            2'b01:   rx_thr = depth_q ? 5'h08 : 5'h03;
            2'b10:   rx_thr = depth_q ? 5'h0C : 5'h06;
            default: rx_thr = depth;
        endcase
        case (tx_code_q)
            2'b00:   tx_thr = depth;
            2'b01:   tx_thr = depth_q ? 5'h08 : 5'h04;
            2'b10:   tx_thr = depth_q ? 5'h0C : 5'h06;
            default: tx_thr = 5'h01;
        endcase
    end

    assign RX_LEVEL_REQ = rx_cnt >= rx_thr;
    assign TX_LEVEL_REQ = tx_free >= tx_thr;

    //------------------------------------------------------------
    // Receiver
    //------------------------------------------------------------
    logic       rxd_m_q;
    logic       rxd_s_q;
    rx_state_e  rx_st_q;
    logic [7:0] rx_tim_q;
    logic [3:0] rx_bit_q;
    logic [8:0] rx_sh_q;
    logic       pend_q;
    logic       overrun_q;
    logic       flow_neg_q;
    wire  [3:0] len     = {2'b00, mode_one_q[1:0]} + 4'h5;
    wire        par_on  = !mode_one_q[4];
    wire  [3:0] nbits   = len + {3'b000, par_on};
    wire        rx_tick = rx_tim_q == 8'h00;
    wire        valid_start = rx_st_q == RX_START && rx_tick && !rxd_s_q;
    wire  [7:0] dmask   = 8'hFF >> (4'h8 - len);
    wire  [7:0] rx_data = rx_sh_q[7:0] & dmask;
    wire        rx_pbit = rx_sh_q[len];
    wire        rx_pe   = mode_one_q[3] ? (rx_pbit != mode_one_q[2])
                        : ((^rx_data) ^ rx_pbit ^ mode_one_q[2]);
    wire        rx_done = rx_st_q == RX_STOP && rx_tick;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rxd_m_q <= 1'b1;
            rxd_s_q <= 1'b1;
        end
        else
        begin
            rxd_m_q <= RXD;
            rxd_s_q <= rxd_m_q;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rx_st_q  <= RX_IDLE;
            rx_tim_q <= 8'h00;
            rx_bit_q <= 4'h0;
            rx_sh_q  <= 9'h000;
        end
        else
        begin
            rx_tim_q <= rx_tick ? 8'(`BIT_CYCLES - 1) : rx_tim_q - 8'h01;
            case (rx_st_q)
                RX_IDLE:
                begin
                    rx_tim_q <= 8'(`BIT_CYCLES / 2 - 1);
                    if (!rxd_s_q)
                        rx_st_q <= RX_START;
                end
                RX_START:
                    if (rx_tick)
                    begin
                        rx_bit_q <= 4'h0;
                        rx_sh_q  <= 9'h000;
                        rx_st_q  <= rxd_s_q ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_sh_q[rx_bit_q] <= rxd_s_q;
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == nbits - 4'h1)
                            rx_st_q <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_tick)
                        rx_st_q <= RX_IDLE;
                default:
                    rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // A finished character waits in rx_in_q while the queue is full; that is the
    // one extra character the flow-control window allows for.
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rx_in_q    <= '0;
            pend_q     <= 1'b0;
            overrun_q  <= 1'b0;
            flow_neg_q <= 1'b0;
        end
        else
        begin
            if (rx_rst)
                pend_q <= 1'b0;
            else if (rx_done && !(pend_q && overrun_q))
            begin
                rx_in_q.data          <= rx_data;
                rx_in_q.framing_fault <= !rxd_s_q;
                rx_in_q.parity_fault  <= par_on && rx_pe;
                rx_in_q.brk           <= !rxd_s_q && rx_sh_q == 9'h000;
                pend_q                <= 1'b1;
            end
            else if (rx_push)
                pend_q <= 1'b0;
            if (valid_start && pend_q)
                overrun_q <= 1'b1;
            else if (err_rst || rx_rst)
                overrun_q <= 1'b0;
            if (valid_start && rx_full && mode_one_q[`MODE_ONE_FLOW])
                flow_neg_q <= 1'b1;
            else if (!rx_full && !pend_q)
                flow_neg_q <= 1'b0;
        end
    end

    // Character arriving while one already waits is dropped, not queued.
    assign rx_push = pend_q && !rx_full && !rx_rst;

    assign CHANNEL_A_REQUEST_TO_SEND_N = !out_port_q[0] || flow_neg_q;
    assign OUTPUT_PIN_ONE = out_port_q[1];

    //------------------------------------------------------------
    // Error status
    //------------------------------------------------------------
    logic [2:0] err_acc_q;
    wire  [2:0] top_err = (rx_cnt != 5'h00) ?
        {rx_top.brk, rx_top.framing_fault, rx_top.parity_fault} : 3'b000;
    wire  [2:0] err_view = mode_one_q[`MODE_ONE_ERRSTY] ? err_acc_q
                                                      : top_err;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            err_acc_q <= 3'b000;
        else
            // A flushed top character must not re-set what the reset clears
            err_acc_q <= ((err_rst || rx_rst) ? 3'b000 : err_acc_q)
                       | (rx_rst ? 3'b000 : top_err);
    end

    //------------------------------------------------------------
    // Transmitter
    //------------------------------------------------------------
    logic       cts_m_q;
    logic       cts_s_q;
    logic [7:0] tx_tim_q;
    logic [3:0] tx_left_q;
    logic [11:0] tx_sh_q;
    logic [11:0] frame;
    wire        tx_busy = tx_left_q != 4'h0;
    wire        tx_tick = tx_tim_q == 8'h00;
    wire        tx_par  = mode_one_q[3] ? mode_one_q[2]
                        : (^(tx_top & dmask)) ^ mode_one_q[2];

    assign tx_pop = !tx_busy && tx_cnt != 5'h00 && !cts_s_q;
    assign TXD    = tx_busy ? tx_sh_q[0] : 1'b1;

    always_comb
    begin
        frame = 12'hFFF;
        frame[0] = 1'b0;
        for (int i = 0; i < 8; i++)
            if (i < len)
                frame[i + 1] = tx_top[i];
        if (par_on)
            frame[len + 4'h1] = tx_par;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cts_m_q   <= 1'b1;
            cts_s_q   <= 1'b1;
            tx_tim_q  <= 8'h00;
            tx_left_q <= 4'h0;
            tx_sh_q   <= 12'hFFF;
        end
        else
        begin
            cts_m_q <= CLEAR_TO_SEND_N;
            cts_s_q <= cts_m_q;
            if (tx_pop)
            begin
                tx_sh_q   <= frame;
                tx_left_q <= nbits + 4'h2;
                tx_tim_q  <= 8'(`BIT_CYCLES - 1);
            end
            else if (tx_busy)
            begin
                tx_tim_q <= tx_tick ? 8'(`BIT_CYCLES - 1) : tx_tim_q - 8'h01;
                if (tx_tick)
                begin
                    tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
                    tx_left_q <= tx_left_q - 4'h1;
                end
            end
        end
    end

    //------------------------------------------------------------
    // Interrupts
    //------------------------------------------------------------
    logic      rx_req_q;
    logic      tx_req_q;
    logic      ovr_q;
    irq_bits_s irq_set;
    wire [2:0] irq_clr = (wr && hit_is) ? PWDATA[2:0] : 3'b000;

    assign irq_set.rx_level = RX_LEVEL_REQ && !rx_req_q;
    assign irq_set.tx_level = TX_LEVEL_REQ && !tx_req_q;
    assign irq_set.overrun  = overrun_q && !ovr_q;
    assign IRQ = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rx_req_q   <= 1'b0;
            tx_req_q   <= 1'b0;
            ovr_q      <= 1'b0;
            irq_stat_q <= '0;
        end
        else
        begin
            rx_req_q   <= RX_LEVEL_REQ;
            tx_req_q   <= TX_LEVEL_REQ;
            ovr_q      <= overrun_q;
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    //------------------------------------------------------------
    // Read data
    //------------------------------------------------------------
    wire [7:0] status = {err_view, overrun_q, tx_cnt == 5'h00,
                         tx_cnt != depth, rx_full, rx_cnt != 5'h00};
    wire [7:0] m1_view = ptr_q ? mode_two_q : mode_one_q;

    assign PRDATA = hit_m1  ? {24'h000000, m1_view}
                  : hit_m0  ? {24'h000000, mode_zero_q}
                  : hit_st  ? {24'h000000, status}
                  : hit_dat ? {24'h000000, rx_top.data}
                  : hit_op  ? {30'h00000000, out_port_q}
                  : hit_is  ? {29'h00000000, irq_stat_q}
                  : hit_im  ? {29'h00000000, irq_mask_q}
                  : 32'h00000000;
endmodule

// >>> src/uart_chan_defs.svh
// Constants of the channel: register offsets, field positions, command codes, timing
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef UART_CHAN_DEFS_SVH
`define UART_CHAN_DEFS_SVH

`define OFS_MODE_ONE     8'h00
`define OFS_MODE_ZERO    8'h04
`define OFS_COMMAND      8'h08
`define OFS_STATUS       8'h0C
`define OFS_DATA         8'h10
`define OFS_OUT_PORT     8'h14
`define OFS_IRQ_STATUS   8'h18
`define OFS_IRQ_MASK     8'h1C

`define MODE_ONE_FLOW    7
`define MODE_ONE_RXLOW   6
`define MODE_ONE_ERRSTY  5
`define MODE_ZERO_RXHIGH 6
`define MODE_ZERO_DEPTH  3

`define CMD_SET_POINTER  4'h1
`define CMD_RX_RESET     4'h2
`define CMD_ERR_RESET    4'h4

`define RESET_MODE       8'h00
`define QUEUE_MAX        5'h10
`define QUEUE_SMALL      5'h08

`define BIT_TIME_NS      1600
`define CLK_PERIOD_NS    100
`define BIT_CYCLES       (`BIT_TIME_NS / `CLK_PERIOD_NS)

`endif

// >>> src/uart_chan_pkg.sv
// Types shared by the channel logic
package uart_chan_pkg;
    typedef struct packed {
        logic       brk;
        logic       framing_fault;
        logic       parity_fault;
        logic [7:0] data;
    } rx_char_s;

    typedef struct packed {
        logic rx_level;
        logic tx_level;
        logic overrun;
    } irq_bits_s;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_e;
endpackage

// >>> verif/uart_chan_assertions.sv
// Port-level checker of one serial channel
module uart_chan_assertions (
    input wire logic        CLK,            // Clock
    input wire logic        RESET_N,        // Reset, low
    input wire logic        PSEL,           // Select
    input wire logic        PENABLE,        // Access
    input wire logic        PWRITE,         // Direction
    input wire logic [7:0]  PADDR,          // Address
    input wire logic [31:0] PWDATA,         // Write data
    input wire logic        PREADY,         // Ready
    input wire logic        PSLVERR,        // Error
    input wire logic        CHANNEL_A_REQUEST_TO_SEND_N, // Flow
    input wire logic        OUTPUT_PIN_ONE, // Port bit one
    input wire logic        RX_LEVEL_REQ,   // Rx fill
    input wire logic        TX_LEVEL_REQ,   // Tx fill
    input wire logic        IRQ             // Interrupt
);
    //--------------------------------
    // Properties
    //--------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    wire acc   = PSEL && PENABLE;
    wire wr    = acc && PWRITE;
    wire wport = wr && PADDR == 8'h14;
    AST_READY: assert property (acc |-> PREADY)
        else $error("access without ready");
    AST_UNMAPPED: assert property (acc && PADDR > 8'h1C |-> PSLVERR)
        else $error("unmapped access not refused");
    AST_PORT_ONE: assert property (wport |=> OUTPUT_PIN_ONE == $past(PWDATA[1]))
        else $error("port bit one wrong");
    AST_RTS_OFF: assert property (wport && !PWDATA[0] |=> CHANNEL_A_REQUEST_TO_SEND_N)
        else $error("flow output not negated");
    AST_PORT_HOLD: assert property (!wport |=> $stable(OUTPUT_PIN_ONE))
        else $error("port bit moved");
    AST_RX_FALL: assert property ($fell(RX_LEVEL_REQ) |-> $past(acc))
        else $error("rx request fell alone");
    AST_TX_FALL: assert property ($fell(TX_LEVEL_REQ) |-> $past(wr))
        else $error("tx request fell alone");
    AST_MASK_OFF: assert property (wr && PADDR == 8'h1C && PWDATA[2:0] == 3'h0 |=> !IRQ)
        else $error("masked interrupt high");
    C_FLOW: cover property ($rose(CHANNEL_A_REQUEST_TO_SEND_N) && !$past(wport));
    C_IRQ: cover property ($rose(IRQ));
    C_RXREQ: cover property (RX_LEVEL_REQ ##1 acc);
endmodule

bind uart_chan uart_chan_assertions u_chk (.*);

// >>> verif/uart_line_model.sv
// Remote serial transmitter feeding the channel
module uart_line_model (
    input  wire logic clk,   // Bench clock
    input  wire logic cts_n, // Low permits a character
    output logic      txd    // Line, idle high
);
    timeunit 1ns;
    timeprecision 1ns;
    //--------------------------------
    // Character sender
    //--------------------------------
    bit ignore = 1'b0; // Overrun test only
    bit stuck  = 1'b0; // Permission to send never came
    initial txd = 1'b1;
    task automatic send(input logic [7:0] b, input logic fe);
        int n;
        n = 0;
        while (cts_n && !ignore && n < 50000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50000)
            stuck = 1'b1;
        // Low stop bit gives a framing fault
        for (int i = 0; i < 10; i++)
        begin
            txd <= (i == 0) ? 1'b0 : (i == 9) ? !fe : b[i - 1];
            repeat (16) @(posedge clk);
        end
        txd <= 1'b1;
        repeat (16) @(posedge clk);
    endtask
endmodule

// >>> verif/uart_chan_tb.sv
// Self-checking bench of one serial channel
module uart_chan_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uart_chan_pkg::*;
    logic        clk, reset_n, psel, penable, pwrite, cts_n, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, rxd, rts_n, pin1, rxreq, txreq, irq, txd;
    int          mismatches, tests_run, seed, big, c, exq[$];
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %0t got %h exp %h", $time, (a), (e)); end end
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    uart_chan u_dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .TXD(txd), .CLEAR_TO_SEND_N(cts_n),
        .CHANNEL_A_REQUEST_TO_SEND_N(rts_n), .OUTPUT_PIN_ONE(pin1),
        .RX_LEVEL_REQ(rxreq), .TX_LEVEL_REQ(txreq), .IRQ(irq));
    uart_line_model u_line (.clk(clk), .cts_n(rts_n), .txd(rxd));
    //--------------------------------
    // Bus and line tasks
    //--------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1)
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic mode1(input logic [7:0] v);
        apb(1'b1, 8'h08, 32'h10);
        apb(1'b1, 8'h00, {24'h0, v});
    endtask
    task automatic rx(input logic fe);
        logic [7:0] b;
        b = 8'($random(seed));
        u_line.send(b, fe);
        `CHK(u_line.stuck, 1'b0)
        exq.push_back(b);
        repeat (4) @(posedge clk);
    endtask
    task automatic pop1();
        int e;
        e = exq.pop_front();
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd[7:0], e[7:0])
    endtask
    task automatic pop_all();
        while (exq.size() > 0)
            pop1();
    endtask
    task automatic drain();
        int n;
        n = 0;
        cts_n <= 1'b0;
        do
        begin
            apb(1'b0, 8'h0C, 32'h0);
            n++;
        end
        while (rd[3] !== 1'b1 && n < 2000);
        `CHK(rd[3], 1'b1)
        cts_n <= 1'b1;
    endtask
    task automatic tx_chk();
        logic [7:0] b;
        int n;
        b = 8'($random(seed));
        n = 0;
        cts_n <= 1'b0;
        apb(1'b1, 8'h10, {24'h0, b});
        `CHK(txreq, 1'b0)
        while (txd !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            `CHK(txd, (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1])
            repeat (16) @(posedge clk);
        end
        `CHK(txreq, 1'b1)
        cts_n <= 1'b1;
    endtask
    function automatic int rx_thr(input int b, input int k);
        int t8[4]  = '{1, 3, 6, 8};
        int t16[4] = '{1, 8, 12, 16};
        return b ? t16[k] : t8[k];
    endfunction
    function automatic int tx_thr(input int b, input int k);
        int dep;
        dep = b ? 16 : 8;
        return k == 0 ? dep : k == 1 ? dep / 2 : k == 2 ? dep * 3 / 4 : 1;
    endfunction
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    //--------------------------------
    // Scenarios
    //--------------------------------
    initial
    begin
        seed = 32'h0C9E;
        mismatches = 0;
        tests_run = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cts_n = 1'b1;
        reset_n = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, 8'h00, 32'h13);
        apb(1'b1, 8'h00, 32'h0);
        mode1(8'h13);
        apb(1'b1, 8'h08, 32'h10);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h13)
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h08, 32'h10);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h13)
        apb(1'b1, 8'h14, 32'h3);
        `CHK(rts_n, 1'b0)
        `CHK(pin1, 1'b1)
        for (int k = 0; k < 8; k++)
        begin
            big = k / 4;
            c = k % 4;
            apb(1'b1, 8'h04, {25'h0, c[1], c[1:0], big[0], 3'h0});
            mode1({1'b0, c[0], 6'h13});
            for (int n = 1; n <= 8 + 8 * big; n++)
            begin
                rx(1'b0);
                `CHK(rxreq, n >= rx_thr(big, c))
                apb(1'b1, 8'h10, n);
                `CHK(txreq, 8 + 8 * big - n >= tx_thr(big, c))
            end
            pop_all();
            drain();
        end
        apb(1'b1, 8'h04, 32'h0);
        mode1(8'h13);
        rx(1'b0);
        rx(1'b0);
        apb(1'b1, 8'h04, 32'h40);
        mode1(8'h53);
        `CHK(rxreq, 1'b1)
        pop1();
        `CHK(rxreq, 1'b0)
        pop_all();
        mode1(8'h93);
        repeat (9) rx(1'b0);
        `CHK(rts_n, 1'b1)
        apb(1'b0, 8'h14, 32'h0);
        `CHK(rd[0], 1'b1)
        u_line.ignore = 1'b1;
        rx(1'b0);
        u_line.ignore = 1'b0;
        void'(exq.pop_back());
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd[4], 1'b1)
        pop_all();
        `CHK(rts_n, 1'b0)
        mode1(8'h13);
        apb(1'b1, 8'h08, 32'h40);
        rx(1'b0);
        rx(1'b1);
        rx(1'b0);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, 8'h0C, 32'h0);
            `CHK(rd[6], i == 1)
            pop1();
        end
        mode1(8'h33);
        apb(1'b1, 8'h08, 32'h40);
        rx(1'b1);
        rx(1'b0);
        pop_all();
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd[6], 1'b1)
        apb(1'b1, 8'h08, 32'h40);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd[6], 1'b0)
        `CHK(rd[4], 1'b0)
        rx(1'b1);
        void'(exq.pop_back());
        apb(1'b1, 8'h08, 32'h20);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd[6], 1'b0)
        `CHK(rd[0], 1'b0)
        apb(1'b1, 8'h1C, 32'h2);
        `CHK(irq, 1'b1)
        apb(1'b1, 8'h18, 32'h2);
        `CHK(irq, 1'b0)
        apb(1'b1, 8'h1C, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        tx_chk();
        apb(1'b1, 8'h14, 32'h0);
        `CHK(rts_n, 1'b1)
        test_done();
    end
endmodule
